// >>> hdl/gsp_params.svh
// Purpose: Constants shared by both ends of the sensor serial port
// Assumes: 25 MHz system clock
// Notes: Index map beyond the identity register is local to this port
`ifndef GSP_PARAMS_SVH
`define GSP_PARAMS_SVH
`define GSP_ADDR_HI6 6'h34
`define GSP_IDX_IDENT 8'h00
`define GSP_IDX_RES_LO 8'h1b
`define GSP_IDX_RES_HI 8'h22
`define GSP_IDX_QCNT_H 8'h3a
`define GSP_IDX_QCNT_L 8'h3b
`define GSP_IDX_QDATA 8'h3c
`define GSP_NREG 64
`define GSP_NRES 8
`define GSP_QDEPTH 512
`define GSP_QCNT_FULL 10'h200
`define GSP_CLK_NS 40
`define GSP_QTR_NS 625
`define GSP_QTR_CYC ((`GSP_QTR_NS + `GSP_CLK_NS - 1) / `GSP_CLK_NS)
`define GSP_SYNC_RST 3'h7
`endif

// >>> hdl/gsp_pkg.sv
// Purpose: Types shared by both ends of the sensor serial port
// Assumes: Nothing beyond the constants header
// Notes: Types only
package gsp_pkg;
  typedef enum {GSP_S_IDLE, GSP_S_RX, GSP_S_ACK, GSP_S_STRETCH, GSP_S_TX,
    GSP_S_TXACK} gsp_sst_e;
  typedef enum {GSP_PH_ADDR, GSP_PH_INDEX, GSP_PH_DATA} gsp_phase_e;
  typedef enum {GSP_M_IDLE, GSP_M_START, GSP_M_BYTE, GSP_M_STOP} gsp_mst_e;
  typedef enum logic [1:0] {GSP_OP_START = 2'h0, GSP_OP_WRITE = 2'h1,
    GSP_OP_READ = 2'h2, GSP_OP_STOP = 2'h3} gsp_op_e;
endpackage

// >>> hdl/gsp_if.sv
// Purpose: Two-wire bus between processor end and sensor end
// Assumes: Open-drain lines with pull-ups
// Notes: A line is low while any enabled driver outputs low
`timescale 1ns/100ps
interface gsp_if;
  logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe;
  logic s_scl_o, s_scl_oe, s_sda_o, s_sda_oe;
  logic scl, sda;
  assign scl = (m_scl_oe ? m_scl_o : 1'b1) & (s_scl_oe ? s_scl_o : 1'b1);
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
  modport dev (input scl, sda, output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe);
  modport host (input scl, sda, output m_scl_o, m_scl_oe, m_sda_o,
    m_sda_oe);
endinterface

// >>> hdl/gsp_slave.sv
// Purpose: Sensor end of the two-wire register port
// Assumes: clk at 25 MHz, bus pins sampled through three flops
// Notes: Register file, result registers and 512-byte queue live here
`timescale 1ns/100ps
`include "gsp_params.svh"
module gsp_slave
  import gsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus
  gsp_if.dev bus,
  // Strap
  input wire logic address_select_pin,
  // Sensor results
  input wire logic res_we,
  input wire logic [2:0] res_sel,
  input wire logic [7:0] res_data,
  // Sample queue fill
  input wire logic q_push,
  input wire logic [7:0] q_data,
  output logic q_full,
  // Register write notice
  output logic wr_pulse_r,
  output logic [7:0] wr_idx_r,
  output logic [7:0] wr_data_r
);
  logic [2:0] scl_s, sda_s, sel_s;
  logic scl_f, sda_f, scl_q, sda_q, sel_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  gsp_sst_e st_r;
  gsp_phase_e ph_r;
  logic [2:0] bit_r;
  logic full_r, rw_r, mack_r, sda_oe_r, scl_oe_r;
  logic [7:0] sh_r, idx_r, tx_r, rd_c;
  logic [7:0] gen_r [`GSP_NREG];
  logic [7:0] res_r [`GSP_NRES];
  logic [7:0] q_r [`GSP_QDEPTH];
  logic [8:0] wp_r, rp_r;
  logic [9:0] cnt_r;
  logic pop_c, push_c, wr_c;

  function automatic logic is_ro(input logic [7:0] i);
    is_ro = (i == `GSP_IDX_IDENT) || (i == `GSP_IDX_QCNT_H) ||
      (i == `GSP_IDX_QCNT_L) || (i == `GSP_IDX_QDATA) ||
      (i >= `GSP_IDX_RES_LO && i <= `GSP_IDX_RES_HI) ||
      (i >= 8'(`GSP_NREG));
  endfunction

  // Three-flop sampling; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_s <= `GSP_SYNC_RST;
      sda_s <= `GSP_SYNC_RST;
      sel_s <= 3'h0;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sel_r <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
      sel_s <= {sel_s[1:0], address_select_pin};
      if (scl_s[2] == scl_s[1]) scl_f <= scl_s[1];
      if (sda_s[2] == sda_s[1]) sda_f <= sda_s[1];
      if (sel_s[2] == sel_s[1]) sel_r <= sel_s[1];
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_c = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_c = scl_f & scl_q & ~sda_q & sda_f;

  // Open drain: only ever pull low
  assign bus.s_scl_o = 1'b0;
  assign bus.s_sda_o = 1'b0;
  assign bus.s_scl_oe = scl_oe_r;
  assign bus.s_sda_oe = sda_oe_r;

  always_comb begin
    rd_c = 8'h00;
    if (idx_r == `GSP_IDX_IDENT)
      rd_c = {1'b0, `GSP_ADDR_HI6, sel_r};
    else if (idx_r == `GSP_IDX_QCNT_H)
      rd_c = {6'h00, cnt_r[9:8]};
    else if (idx_r == `GSP_IDX_QCNT_L)
      rd_c = cnt_r[7:0];
    else if (idx_r == `GSP_IDX_QDATA)
      rd_c = q_r[rp_r];
    else if (idx_r >= `GSP_IDX_RES_LO && idx_r <= `GSP_IDX_RES_HI)
      rd_c = res_r[3'(idx_r - `GSP_IDX_RES_LO)];
    else if (idx_r < 8'(`GSP_NREG))
      rd_c = gen_r[idx_r[5:0]];
  end

  assign pop_c = (st_r == GSP_S_STRETCH) && (idx_r == `GSP_IDX_QDATA) &&
    (cnt_r != 10'h000);
  assign push_c = q_push && !q_full;
  assign q_full = (cnt_r == `GSP_QCNT_FULL);
  assign wr_c = (st_r == GSP_S_RX) && scl_fall && full_r &&
    (ph_r == GSP_PH_DATA) && !start_c && !stop_c;

  // Protocol engine
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= GSP_S_IDLE;
      ph_r <= GSP_PH_ADDR;
      bit_r <= 3'h0;
      full_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sh_r <= 8'h00;
      idx_r <= 8'h00;
      tx_r <= 8'h00;
    end else if (start_c) begin
      st_r <= GSP_S_RX;
      ph_r <= GSP_PH_ADDR;
      bit_r <= 3'h0;
      full_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else if (stop_c) begin
      st_r <= GSP_S_IDLE;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else begin
      case (st_r)
        GSP_S_IDLE: begin
          sda_oe_r <= 1'b0;
          scl_oe_r <= 1'b0;
        end
        GSP_S_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_f};
            bit_r <= bit_r + 3'h1;
            full_r <= (bit_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_r <= 1'b0;
            case (ph_r)
              GSP_PH_ADDR: begin
                if (sh_r[7:1] == {`GSP_ADDR_HI6, sel_r}) begin
                  rw_r <= sh_r[0];
                  ph_r <= sh_r[0] ? GSP_PH_DATA : GSP_PH_INDEX;
                  sda_oe_r <= 1'b1;
                  st_r <= GSP_S_ACK;
                end else begin
                  st_r <= GSP_S_IDLE;
                end
              end
              GSP_PH_INDEX: begin
                idx_r <= sh_r;
                ph_r <= GSP_PH_DATA;
                sda_oe_r <= 1'b1;
                st_r <= GSP_S_ACK;
              end
              default: begin
                idx_r <= idx_r + 8'h01;
                sda_oe_r <= 1'b1;
                st_r <= GSP_S_ACK;
              end
            endcase
          end
        end
        GSP_S_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            bit_r <= 3'h0;
            if (rw_r) begin
              st_r <= GSP_S_STRETCH;
              scl_oe_r <= 1'b1;
            end else begin
              st_r <= GSP_S_RX;
            end
          end
        end
        GSP_S_STRETCH: begin
          // SCL is held low while the byte is fetched
          tx_r <= rd_c;
          sda_oe_r <= ~rd_c[7];
          if (idx_r != `GSP_IDX_QDATA) idx_r <= idx_r + 8'h01;
          bit_r <= 3'h0;
          full_r <= 1'b0;
          scl_oe_r <= 1'b0;
          st_r <= GSP_S_TX;
        end
        GSP_S_TX: begin
          if (scl_rise) begin
            bit_r <= bit_r + 3'h1;
            full_r <= (bit_r == 3'h7);
          end else if (scl_fall) begin
            if (full_r) begin
              sda_oe_r <= 1'b0;
              st_r <= GSP_S_TXACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
        end
        GSP_S_TXACK: begin
          if (scl_rise) mack_r <= ~sda_f;
          else if (scl_fall) begin
            if (mack_r) begin
              st_r <= GSP_S_STRETCH;
              scl_oe_r <= 1'b1;
            end else begin
              st_r <= GSP_S_IDLE;
            end
          end
        end
        default: st_r <= GSP_S_IDLE;
      endcase
    end
  end

  // Register file writes; read-only indexes keep their contents
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pulse_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_pulse_r <= wr_c && !is_ro(idx_r);
      if (wr_c) begin
        wr_idx_r <= idx_r;
        wr_data_r <= sh_r;
      end
      if (wr_c && !is_ro(idx_r)) gen_r[idx_r[5:0]] <= sh_r;
    end
  end

  always_ff @(posedge clk) begin
    if (res_we) res_r[res_sel] <= res_data;
  end

  // Queue; a pop on an empty queue returns stale data and counts nothing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_r <= 9'h000;
      rp_r <= 9'h000;
      cnt_r <= 10'h000;
    end else begin
      if (push_c) begin
        q_r[wp_r] <= q_data;
        wp_r <= wp_r + 9'h001;
      end
      if (pop_c) rp_r <= rp_r + 9'h001;
      if (push_c && !pop_c) cnt_r <= cnt_r + 10'h001;
      else if (pop_c && !push_c) cnt_r <= cnt_r - 10'h001;
    end
  end
endmodule

// >>> hdl/gsp_master.sv
// Purpose: Processor end of the two-wire register port
// Assumes: clk at 25 MHz; one bus command at a time
// Notes: Quarter-bit enable gives SCL near 390 kHz, under the 400 kHz cap
`timescale 1ns/100ps
`include "gsp_params.svh"
module gsp_master
  import gsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus
  gsp_if.host bus,
  // Command
  input wire logic cmd_valid,
  input wire gsp_op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic cmd_ready,
  // Response
  output logic rsp_valid_r,
  output logic [7:0] rsp_data_r,
  output logic rsp_ack_r
);
  localparam int QTR = `GSP_QTR_CYC;
  logic [2:0] scl_s, sda_s;
  logic scl_f, sda_f, tick;
  logic [4:0] div_r;
  gsp_mst_e st_r;
  gsp_op_e op_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ack_r, mack_r, scl_oe_r, sda_oe_r, hold_c;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_s <= `GSP_SYNC_RST;
      sda_s <= `GSP_SYNC_RST;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
      if (scl_s[2] == scl_s[1]) scl_f <= scl_s[1];
      if (sda_s[2] == sda_s[1]) sda_f <= sda_s[1];
    end
  end

  // Quarter-bit enable; sized so a full bit is never under 2.5 us
  always_ff @(posedge clk) begin
    if (!resetn || st_r == GSP_M_IDLE) div_r <= 5'h00;
    else if (tick) div_r <= 5'h00;
    else div_r <= div_r + 5'h01;
  end
  assign tick = (div_r == 5'(QTR - 1));

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_oe = sda_oe_r;
  assign cmd_ready = (st_r == GSP_M_IDLE);
  // Wait out a stretched clock before the sampling quarter
  assign hold_c = (q_r == 2'h2) && !scl_f;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= GSP_M_IDLE;
      op_r <= GSP_OP_START;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      mack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_ack_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (st_r)
        GSP_M_IDLE: begin
          if (cmd_valid) begin
            op_r <= cmd_op;
            sh_r <= cmd_data;
            mack_r <= cmd_ack;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            case (cmd_op)
              GSP_OP_START: st_r <= GSP_M_START;
              GSP_OP_STOP: st_r <= GSP_M_STOP;
              default: st_r <= GSP_M_BYTE;
            endcase
          end
        end
        GSP_M_START: begin
          if (tick && !hold_c) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
              end
              2'h2: sda_oe_r <= sda_f;
              2'h3: begin
                scl_oe_r <= 1'b1;
                st_r <= GSP_M_IDLE;
              end
              default: ;
            endcase
          end
        end
        GSP_M_STOP: begin
          if (tick && !hold_c) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                scl_oe_r <= 1'b1;
                sda_oe_r <= 1'b1;
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0;
              2'h3: st_r <= GSP_M_IDLE;
              default: ;
            endcase
          end
        end
        GSP_M_BYTE: begin
          if (tick && !hold_c) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                scl_oe_r <= 1'b1;
                if (bit_r == 4'h8)
                  sda_oe_r <= (op_r == GSP_OP_READ) && mack_r;
                else
                  sda_oe_r <= (op_r == GSP_OP_WRITE) && !sh_r[7];
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (bit_r == 4'h8) ack_r <= ~sda_f;
                else sh_r <= {sh_r[6:0], sda_f};
              end
              2'h3: begin
                scl_oe_r <= 1'b1;
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8) begin
                  sda_oe_r <= 1'b0;
                  rsp_valid_r <= 1'b1;
                  rsp_data_r <= sh_r;
                  rsp_ack_r <= (op_r == GSP_OP_READ) ? mack_r : ack_r;
                  st_r <= GSP_M_IDLE;
                end
              end
              default: ;
            endcase
          end
        end
        default: st_r <= GSP_M_IDLE;
      endcase
    end
  end
endmodule

// >>> verif/gsp_checker.sv
// Purpose: Bus-level checks on the two-wire sensor port
// Assumes: Lines and pull-down enables sampled on the system clock
// Notes: Bit count restarts at every start; first byte is the address
`timescale 1ns/100ps
`include "gsp_params.svh"
module gsp_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus lines and pull-down enables
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe,
  input wire logic s_scl_oe,
  input wire logic s_sda_oe
);
  logic scl_q, sda_q, first_r;
  logic [3:0] nbit_r;
  logic [7:0] shf_r, per_r;
  wire srise = scl && !scl_q;
  wire start_c = scl && scl_q && sda_q && !sda;
  wire stop_c = scl && scl_q && !sda_q && sda;
  wire ack9 = srise && nbit_r == 4'h8;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  always_ff @(posedge clk) begin
    if (srise)
      shf_r <= {shf_r[6:0], sda};
  end
  always_ff @(posedge clk) begin
    if (!resetn || start_c) begin
      nbit_r <= 4'h0;
      first_r <= 1'b1;
    end else if (ack9) begin
      nbit_r <= 4'h0;
      first_r <= 1'b0;
    end else if (srise)
      nbit_r <= nbit_r + 4'h1;
  end
  // Saturates so the first clock after reset is never judged too fast
  always_ff @(posedge clk) begin
    if (!resetn)
      per_r <= 8'hff;
    else if ($rose(m_scl_oe))
      per_r <= 8'h01;
    else if (per_r != 8'hff)
      per_r <= per_r + 8'h01;
  end
  sequence fall_soon;
    ##[1:40] $fell(scl);
  endsequence
  sequence addr_bits;
    ##[1:600] (srise && nbit_r == 4'h7);
  endsequence
  addr_match_a:
  assert property (ack9 && first_r && s_sda_oe |->
    shf_r[7:2] == `GSP_ADDR_HI6)
    else $error("address acknowledged that is not ours");
  ack_hold_a:
  assert property (ack9 && s_sda_oe |-> (s_sda_oe && scl) [*8])
    else $error("acknowledge dropped in clock high");
  sda_lowscl_a:
  assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave data moved while clock high");
  nack_release_a:
  assert property (ack9 && !first_r && sda |-> fall_soon ##8 !s_sda_oe)
    else $error("slave kept driving after not-acknowledge");
  stretch_short_a:
  assert property ($rose(s_scl_oe) |-> ##[1:4] !s_scl_oe)
    else $error("clock stretch too long");
  stop_idle_a:
  assert property (stop_c |-> (!s_sda_oe && !s_scl_oe) [*8])
    else $error("slave active after stop");
  start_quiet_a:
  assert property (start_c |-> !s_sda_oe throughout addr_bits)
    else $error("slave drove data during address");
  scl_rate_a:
  assert property ($rose(m_scl_oe) |-> per_r >= 8'(4 * `GSP_QTR_CYC - 1))
    else $error("serial clock faster than allowed");
endmodule

// >>> verif/sensor_i2c_slave_register_port_tb.sv
// Purpose: Processor end and sensor end joined, driven from both user sides
// Assumes: 25 MHz clock; open-drain lines resolved in the interface
// Notes: Expected results wait in queues until the outputs produce them
`timescale 1ns/100ps
`include "gsp_params.svh"
module sensor_i2c_slave_register_port_tb
  import gsp_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, asel = 1'b0, res_we = 1'b0;
  logic q_push = 1'b0, cmd_valid = 1'b0, cmd_ack = 1'b0;
  logic [2:0] res_sel = 3'h0;
  logic [7:0] res_data = 8'h00, q_data = 8'h00, cmd_data = 8'h00;
  gsp_op_e cmd_op = GSP_OP_START;
  logic q_full, cmd_ready, rsp_valid_r, rsp_ack_r, wr_pulse_r;
  logic [7:0] rsp_data_r, wr_idx_r, wr_data_r;
  logic [6:0] ad = {`GSP_ADDR_HI6, 1'b0};
  logic [8:0] exp_q[$];
  logic [15:0] exp_w[$];
  logic [7:0] wq[$], rq[$], qm[$];
  int n_fail = 0, check_count = 0, seed = 32'h77be4ebf;
  gsp_if bus_if();
  gsp_master gsp_master_inst (.clk(clk), .resetn(resetn), .bus(bus_if.host),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .rsp_valid_r(rsp_valid_r),
    .rsp_data_r(rsp_data_r), .rsp_ack_r(rsp_ack_r));
  gsp_slave gsp_slave_inst (.clk(clk), .resetn(resetn), .bus(bus_if.dev),
    .address_select_pin(asel), .res_we(res_we), .res_sel(res_sel),
    .res_data(res_data), .q_push(q_push), .q_data(q_data), .q_full(q_full),
    .wr_pulse_r(wr_pulse_r), .wr_idx_r(wr_idx_r), .wr_data_r(wr_data_r));
  gsp_checker gsp_checker_inst (.clk(clk), .resetn(resetn),
    .scl(bus_if.scl), .sda(bus_if.sda), .m_scl_oe(bus_if.m_scl_oe),
    .s_scl_oe(bus_if.s_scl_oe), .s_sda_oe(bus_if.s_sda_oe));
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  // Bus byte results: acknowledge bit above the byte
  task automatic cmp_rsp(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write notices: index above data
  task automatic cmp_wr(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: write got %h expected %h", $time, got, exp);
    end
  endtask
  // Flags read straight off the block, and counts of expectations still queued
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: value got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One command, held until the edge that takes it
  task automatic op(input gsp_op_e o, input logic [7:0] d, input logic a,
      input logic [8:0] e);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 4000);
    if (i >= 4000) begin
      n_fail++;
      conclude();
    end
    if (o == GSP_OP_WRITE || o == GSP_OP_READ)
      exp_q.push_back(e);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    cmd_ack <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic hdr(input logic [7:0] idx);
    op(GSP_OP_START, 8'h00, 1'b0, 9'h000);
    op(GSP_OP_WRITE, {ad, 1'b0}, 1'b0, {1'b1, ad, 1'b0});
    op(GSP_OP_WRITE, idx, 1'b0, {1'b1, idx});
  endtask
  // Read-only places must give no write notice
  task automatic wreg(input logic [7:0] idx, input logic ro);
    hdr(idx);
    foreach (wq[k]) begin
      op(GSP_OP_WRITE, wq[k], 1'b0, {1'b1, wq[k]});
      if (!ro)
        exp_w.push_back({idx + 8'(k), wq[k]});
    end
    op(GSP_OP_STOP, 8'h00, 1'b0, 9'h000);
  endtask
  task automatic rreg(input logic [7:0] idx);
    logic more;
    hdr(idx);
    op(GSP_OP_START, 8'h00, 1'b0, 9'h000);
    op(GSP_OP_WRITE, {ad, 1'b1}, 1'b0, {1'b1, ad, 1'b1});
    foreach (rq[k]) begin
      more = k < rq.size() - 1;
      op(GSP_OP_READ, 8'h00, more, {more, rq[k]});
    end
    op(GSP_OP_STOP, 8'h00, 1'b0, 9'h000);
  endtask
  // An empty queue leaves the expectation unknown, which always mismatches
  always @(posedge clk) begin
    logic [8:0] er;
    logic [15:0] ew;
    er = 9'hxxx;
    ew = 16'hxxxx;
    if (rsp_valid_r === 1'b1) begin
      if (exp_q.size() > 0) er = exp_q.pop_front();
      cmp_rsp({rsp_ack_r, rsp_data_r}, er);
    end
    if (wr_pulse_r === 1'b1) begin
      if (exp_w.size() > 0) ew = exp_w.pop_front();
      cmp_wr({wr_idx_r, wr_data_r}, ew);
    end
  end
  initial begin
    logic [7:0] d;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    wq = '{rnd(), rnd()};
    wreg(8'h05, 1'b0);
    rq = wq;
    rreg(8'h05);
    $display("test burst write and read done");
    rq = '{{1'b0, ad}};
    rreg(`GSP_IDX_IDENT);
    asel <= 1'b1;
    ad = {`GSP_ADDR_HI6, 1'b1};
    rq = '{{1'b0, ad}};
    rreg(`GSP_IDX_IDENT);
    op(GSP_OP_START, 8'h00, 1'b0, 9'h000);
    op(GSP_OP_WRITE, 8'hd0, 1'b0, 9'h0d0);
    op(GSP_OP_STOP, 8'h00, 1'b0, 9'h000);
    hdr(8'h07);
    op(GSP_OP_START, 8'h00, 1'b0, 9'h000);
    op(GSP_OP_WRITE, 8'ha0, 1'b0, 9'h0a0);
    op(GSP_OP_STOP, 8'h00, 1'b0, 9'h000);
    $display("test address select done");
    rq.delete();
    for (int s = 0; s < `GSP_NRES; s++) begin
      @(posedge clk);
      d = rnd();
      res_we <= 1'b1;
      res_sel <= 3'(s);
      res_data <= d;
      rq.push_back(d);
    end
    @(posedge clk);
    res_we <= 1'b0;
    wq = '{rnd(), rnd()};
    wreg(`GSP_IDX_RES_LO, 1'b1);
    rreg(`GSP_IDX_RES_LO);
    $display("test result registers done");
    // Last push lands on a full queue and must be dropped
    for (int n = 0; n <= `GSP_QDEPTH; n++) begin
      @(posedge clk);
      d = rnd();
      q_push <= 1'b1;
      q_data <= d;
      if (n < `GSP_QDEPTH)
        qm.push_back(d);
    end
    @(posedge clk);
    q_push <= 1'b0;
    @(posedge clk);
    cmp_val({15'h0000, q_full}, 16'h0001);
    rq = '{8'h02, 8'h00};
    rreg(`GSP_IDX_QCNT_H);
    rq = '{qm[0], qm[1], qm[2]};
    rreg(`GSP_IDX_QDATA);
    rq = '{8'h01, 8'hfd};
    rreg(`GSP_IDX_QCNT_H);
    $display("test sample queue done");
    cmp_val(16'(exp_q.size() + exp_w.size()), 16'h0000);
    conclude();
  end
endmodule
